// File: rtl/rtcdst_top.sv
// Contract
// - alarm byte msb enables that field; only enabled fields are compared
// - pulse mode with seconds enabled at 30 pulses once each minute
// - pulse mode sets alarm flag each trigger; no read or clear needed
// - first mains-to-battery switch stamps time; later ones ignored until cleared
// - writing 1 to clear bit at 09h clears both stamps
// - cleared or fresh stamps read all zero; nonzero means captured
// - battery-to-mains stamp overwritten on every return of mains
// - bit 7 of 20h enables saving time; resets to 0
// - writing enable 0 clears the adjusted flag
// - spring month coded 1 to 12, reset 00h
// - priority bit 1 schedules by week and weekday, 0 by date
// - date field used only while priority bit is 0
// - week/day bits 2:0 hold weekday 0 to 6, reset 00h
// - week/day bits 5:3 hold week 1 to 5; 7 means last week
// - spring date coded 1 to 31, reset 00h
// - spring hour lacks 24h bit, works in either format, reset 00h
// - fall month coded 1 to 12, reset 10h
// - fall date coded 1 to 31, reset 00h
// - fall hour coded like spring hour, reset 00h
// - 10-bit temperature: low byte, then bits 1:0 of high byte
// - temperature code is mean of two successive conversions
// - code is twice kelvin temperature
// - conversions run only while sense enable is 1
`default_nettype none
`include "rtcdst_defs.svh"

module rtcdst_top #(
   parameter int TEMP_W = 10
) (
   input  wire logic                      i_clk,
   input  wire logic                      i_rst_n,
   input  wire logic                      i_reg_wr,
   input  wire logic                      i_reg_rd,
   input  wire rtcdst_pkg::rtcdst_byte_t  i_reg_addr,
   input  wire rtcdst_pkg::rtcdst_byte_t  i_reg_wdata,
   output rtcdst_pkg::rtcdst_byte_t       o_reg_rdata,
   input  wire logic                      i_time_tick,
   input  wire rtcdst_pkg::rtcdst_byte_t  i_sec,
   input  wire rtcdst_pkg::rtcdst_byte_t  i_min,
   input  wire rtcdst_pkg::rtcdst_byte_t  i_hour,
   input  wire rtcdst_pkg::rtcdst_byte_t  i_date,
   input  wire rtcdst_pkg::rtcdst_byte_t  i_month,
   input  wire rtcdst_pkg::rtcdst_byte_t  i_dow,
   input  wire logic                      i_leap_year,
   input  wire logic                      i_on_battery,
   input  wire logic                      i_temp_valid,
   input  wire logic [TEMP_W-1:0]         i_temp_sample,
   output logic                           o_temp_conv_en,
   output logic                           o_dst_advance,
   output logic                           o_dst_retard,
   output logic                           o_alarm_irq_n
);
   import rtcdst_pkg::*;

   initial begin
      if (TEMP_W != 10) begin
         $error("rtcdst_top: TEMP_W must be 10");
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register storage

   rtcdst_byte_t     alarm_q [`RTCDST_ALARM_N];
   rtcdst_byte_t     stamp_mb_q [`RTCDST_STAMP_N];
   rtcdst_byte_t     stamp_bm_q [`RTCDST_STAMP_N];
   rtcdst_byte_t     sp_month_q;
   rtcdst_byte_t     sp_wd_q;
   rtcdst_byte_t     sp_date_q;
   rtcdst_byte_t     sp_hour_q;
   rtcdst_byte_t     fa_month_q;
   rtcdst_byte_t     fa_wd_q;
   rtcdst_byte_t     fa_date_q;
   rtcdst_byte_t     fa_hour_q;
   rtcdst_alm_mode_t alm_mode_q;
   logic             tse_q;
   logic             alarm_flag_q;
   logic             adj_flag_q;
   logic             mb_taken_q;
   logic             batt_q;
   logic [TEMP_W-1:0] first_q;
   logic             have_first_q;
   logic [TEMP_W-1:0] kelvin_code_q;
   logic             alarm_pulse_q;
   logic             adv_q;
   logic             ret_q;
   rtcdst_byte_t     rdata_q;

   logic wr_status;
   logic wr_supply;
   logic clear_stamps;
   logic saving_time_enable_off;
   logic alarm_hit;
   logic sp_hit;
   logic fa_hit;
   logic to_battery;
   logic to_mains;

   assign wr_status    = i_reg_wr && (i_reg_addr == `RTCDST_STATUS_ADDR);
   assign wr_supply    = i_reg_wr && (i_reg_addr == `RTCDST_SUPPLY_ADDR);
   assign clear_stamps = wr_supply
                         && i_reg_wdata[`RTCDST_CLEAR_BIT];
   assign saving_time_enable_off     = i_reg_wr && (i_reg_addr == `RTCDST_SPRING_MONTH)
                         && !i_reg_wdata[`RTCDST_SAVING_TIME_ENABLE_BIT];
   assign to_battery   = i_on_battery && !batt_q;
   assign to_mains     = !i_on_battery && batt_q;

   ////////////////////////////////////////////////////////////////////////
   // host-written control

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sp_month_q <= `RTCDST_SPRING_MONTH_RST;
         sp_wd_q    <= `RTCDST_FIELD_RST;
         sp_date_q  <= `RTCDST_FIELD_RST;
         sp_hour_q  <= `RTCDST_FIELD_RST;
         fa_month_q <= `RTCDST_FALL_MONTH_RST;
         fa_wd_q    <= `RTCDST_FIELD_RST;
         fa_date_q  <= `RTCDST_FIELD_RST;
         fa_hour_q  <= `RTCDST_FIELD_RST;
      end else if (i_reg_wr) begin
         unique case (i_reg_addr)
            `RTCDST_SPRING_MONTH: begin
               sp_month_q <= i_reg_wdata
                  & (`RTCDST_MONTH_MASK | 8'h80);
            end
            `RTCDST_SPRING_WEEK_DAY: begin
               sp_wd_q <= i_reg_wdata & `RTCDST_WEEK_DAY_MASK;
            end
            `RTCDST_SPRING_DATE: begin
               sp_date_q <= i_reg_wdata & `RTCDST_DATE_MASK;
            end
            `RTCDST_SPRING_HOUR: begin
               sp_hour_q <= i_reg_wdata & `RTCDST_HOUR_MASK;
            end
            `RTCDST_FALL_MONTH: begin
               fa_month_q <= i_reg_wdata & `RTCDST_MONTH_MASK;
            end
            `RTCDST_FALL_WEEK_DAY: begin
               fa_wd_q <= i_reg_wdata & `RTCDST_WEEK_DAY_MASK;
            end
            `RTCDST_FALL_DATE: begin
               fa_date_q <= i_reg_wdata & `RTCDST_DATE_MASK;
            end
            `RTCDST_FALL_HOUR: begin
               fa_hour_q <= i_reg_wdata & `RTCDST_HOUR_MASK;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         alm_mode_q <= RTCDST_ALM_SINGLE;
         tse_q      <= 1'b0;
         for (int i = 0; i < `RTCDST_ALARM_N; i++) begin
            alarm_q[i] <= `RTCDST_FIELD_RST;
         end
      end else if (i_reg_wr) begin
         if (i_reg_addr == `RTCDST_INTCTL_ADDR) begin
            alm_mode_q <= rtcdst_alm_mode_t'(
               i_reg_wdata[`RTCDST_PULSE_MODE_BIT]);
         end
         if (i_reg_addr == `RTCDST_TEMPCTL_ADDR) begin
            tse_q <= i_reg_wdata[`RTCDST_TSE_BIT];
         end
         for (int i = 0; i < `RTCDST_ALARM_N; i++) begin
            if (i_reg_addr == `RTCDST_ALARM_BASE + 8'(i)) begin
               alarm_q[i] <= i_reg_wdata;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // alarm compare

   rtcdst_byte_t now [`RTCDST_ALARM_N];
   logic [`RTCDST_ALARM_N-1:0] fld_ok;
   logic [`RTCDST_ALARM_N-1:0] fld_en;

   assign now[0] = i_sec;
   assign now[1] = i_min;
   assign now[2] = i_hour;
   assign now[3] = i_date;
   assign now[4] = i_month;
   assign now[5] = i_dow;

   for (genvar g = 0; g < `RTCDST_ALARM_N; g++) begin : g_alm
      assign fld_en[g] = alarm_q[g][`RTCDST_ALARM_EN_BIT];
      assign fld_ok[g] = !fld_en[g]
                         || (alarm_q[g][6:0] == now[g][6:0]);
   end

   assign alarm_hit = i_time_tick && (|fld_en) && (&fld_ok);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         alarm_flag_q  <= 1'b0;
         alarm_pulse_q <= 1'b0;
      end else begin
         alarm_pulse_q <= alarm_hit && (alm_mode_q == RTCDST_ALM_PULSE);
         if (alarm_hit) begin
            alarm_flag_q <= 1'b1;
         end else if (wr_status
                      && !i_reg_wdata[`RTCDST_ALARM_FLAG_BIT]) begin
            alarm_flag_q <= 1'b0;
         end
      end
   end

   assign o_alarm_irq_n = (alm_mode_q == RTCDST_ALM_PULSE) ?
                          !alarm_pulse_q : !alarm_flag_q;

   ////////////////////////////////////////////////////////////////////////
   // power-transition stamps

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         batt_q     <= 1'b0;
         mb_taken_q <= 1'b0;
         for (int i = 0; i < `RTCDST_STAMP_N; i++) begin
            stamp_mb_q[i] <= `RTCDST_FIELD_RST;
            stamp_bm_q[i] <= `RTCDST_FIELD_RST;
         end
      end else begin
         batt_q <= i_on_battery;
         if (to_battery && !mb_taken_q) begin
            mb_taken_q <= 1'b1;
            for (int i = 0; i < `RTCDST_STAMP_N; i++) begin
               stamp_mb_q[i] <= now[i];
            end
         end else if (clear_stamps) begin
            mb_taken_q <= 1'b0;
            for (int i = 0; i < `RTCDST_STAMP_N; i++) begin
               stamp_mb_q[i] <= `RTCDST_FIELD_RST;
            end
         end
         if (to_mains) begin
            for (int i = 0; i < `RTCDST_STAMP_N; i++) begin
               stamp_bm_q[i] <= now[i];
            end
         end else if (clear_stamps) begin
            for (int i = 0; i < `RTCDST_STAMP_N; i++) begin
               stamp_bm_q[i] <= `RTCDST_FIELD_RST;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // saving-time schedule

   function automatic logic [5:0] bcd_bin(input rtcdst_byte_t b);
      logic [5:0] r;
      r = 6'(b[5:4]) * 6'd10 + 6'(b[3:0]);
      return r;
   endfunction

   function automatic logic [5:0] days_in(input rtcdst_byte_t m,
                                          input logic leap);
      logic [5:0] r;
      unique case (bcd_bin(m))
         6'd2:    r = leap ? 6'd29 : 6'd28;
         6'd4,
         6'd6,
         6'd9,
         6'd11:   r = 6'd30;
         default: r = 6'd31;
      endcase
      return r;
   endfunction

   function automatic logic day_match(input rtcdst_byte_t wd,
                                      input rtcdst_byte_t dt,
                                      input rtcdst_byte_t date,
                                      input rtcdst_byte_t dow,
                                      input rtcdst_byte_t mon,
                                      input logic leap);
      logic [5:0] d;
      logic [2:0] wk;
      logic       wk_ok;
      logic       r;
      d     = bcd_bin(date);
      wk    = 3'((6'(d - 6'd1) / 6'd7) + 6'd1);
      wk_ok = (wd[5:3] == `RTCDST_LAST_WEEK) ?
              (6'(d + 6'd7) > days_in(mon, leap)) :
              (wd[5:3] == wk);
      if (wd[`RTCDST_PRIO_BIT]) begin
         r = wk_ok && (wd[2:0] == dow[2:0]);
      end else begin
         r = (dt[5:0] == date[5:0]);
      end
      return r;
   endfunction

   logic at_hour_top;
   assign at_hour_top = i_time_tick && (i_sec[6:0] == 7'h00)
                        && (i_min[6:0] == 7'h00);

   // hour compare drops the 24h indicator so either format matches
   assign sp_hit = sp_month_q[`RTCDST_SAVING_TIME_ENABLE_BIT] && !adj_flag_q
      && at_hour_top
      && (sp_month_q[4:0] == i_month[4:0])
      && day_match(sp_wd_q, sp_date_q, i_date, i_dow,
                   i_month, i_leap_year)
      && (sp_hour_q[5:0] == i_hour[5:0]);
   assign fa_hit = sp_month_q[`RTCDST_SAVING_TIME_ENABLE_BIT] && adj_flag_q
      && at_hour_top
      && (fa_month_q[4:0] == i_month[4:0])
      && day_match(fa_wd_q, fa_date_q, i_date, i_dow,
                   i_month, i_leap_year)
      && (fa_hour_q[5:0] == i_hour[5:0]);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         adj_flag_q <= 1'b0;
         adv_q      <= 1'b0;
         ret_q      <= 1'b0;
      end else begin
         adv_q <= sp_hit;
         ret_q <= fa_hit;
         if (sp_hit) begin
            adj_flag_q <= 1'b1;
         end else if (fa_hit || saving_time_enable_off) begin
            adj_flag_q <= 1'b0;
         end else if (wr_status
                      && !i_reg_wdata[`RTCDST_ADJ_FLAG_BIT]) begin
            adj_flag_q <= 1'b0;
         end
      end
   end

   assign o_dst_advance = adv_q;
   assign o_dst_retard  = ret_q;

   ////////////////////////////////////////////////////////////////////////
   // temperature averaging

   assign o_temp_conv_en = tse_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         first_q       <= '0;
         have_first_q  <= 1'b0;
         kelvin_code_q <= '0;
      end else if (!tse_q) begin
         have_first_q <= 1'b0;
      end else if (i_temp_valid) begin
         if (!have_first_q) begin
            first_q      <= i_temp_sample;
            have_first_q <= 1'b1;
         end else begin
            // sample already counts half kelvin, so the mean keeps it
            kelvin_code_q <= TEMP_W'(({1'b0, first_q}
                             + {1'b0, i_temp_sample}) >> 1);
            have_first_q  <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q <= 8'h00;
      end else if (i_reg_rd) begin
         rdata_q <= 8'h00;
         unique case (i_reg_addr)
            `RTCDST_STATUS_ADDR: begin
               rdata_q[`RTCDST_ALARM_FLAG_BIT] <= alarm_flag_q;
               rdata_q[`RTCDST_ADJ_FLAG_BIT]   <= adj_flag_q;
            end
            `RTCDST_INTCTL_ADDR:
               rdata_q[`RTCDST_PULSE_MODE_BIT] <= alm_mode_q;
            `RTCDST_TEMPCTL_ADDR:  rdata_q[`RTCDST_TSE_BIT] <= tse_q;
            `RTCDST_SPRING_MONTH:    rdata_q <= sp_month_q;
            `RTCDST_SPRING_WEEK_DAY: rdata_q <= sp_wd_q;
            `RTCDST_SPRING_DATE:     rdata_q <= sp_date_q;
            `RTCDST_SPRING_HOUR:     rdata_q <= sp_hour_q;
            `RTCDST_FALL_MONTH:      rdata_q <= fa_month_q;
            `RTCDST_FALL_WEEK_DAY:   rdata_q <= fa_wd_q;
            `RTCDST_FALL_DATE:       rdata_q <= fa_date_q;
            `RTCDST_FALL_HOUR:       rdata_q <= fa_hour_q;
            `RTCDST_TEMP_LOW_ADDR:   rdata_q <= kelvin_code_q[7:0];
            `RTCDST_TEMP_HIGH_ADDR:
               rdata_q <= {6'h00, kelvin_code_q[9:8]};
            default: begin
               for (int i = 0; i < `RTCDST_ALARM_N; i++) begin
                  if (i_reg_addr == `RTCDST_ALARM_BASE + 8'(i)) begin
                     rdata_q <= alarm_q[i];
                  end
               end
               for (int i = 0; i < `RTCDST_STAMP_N; i++) begin
                  if (i_reg_addr == `RTCDST_STAMP_MB_BASE + 8'(i)) begin
                     rdata_q <= stamp_mb_q[i];
                  end
                  if (i_reg_addr == `RTCDST_STAMP_BM_BASE + 8'(i)) begin
                     rdata_q <= stamp_bm_q[i];
                  end
               end
            end
         endcase
      end
   end

   assign o_reg_rdata = rdata_q;

endmodule
`default_nettype wire

// File: rtl/rtcdst_defs.svh
`ifndef RTCDST_DEFS_SVH
`define RTCDST_DEFS_SVH

// register offsets
`define RTCDST_STATUS_ADDR      8'h07
`define RTCDST_INTCTL_ADDR      8'h08
`define RTCDST_SUPPLY_ADDR      8'h09
`define RTCDST_TEMPCTL_ADDR     8'h0D
`define RTCDST_ALARM_BASE       8'h10
`define RTCDST_ALARM_LAST       8'h15
`define RTCDST_STAMP_MB_BASE    8'h16
`define RTCDST_STAMP_BM_BASE    8'h1B
`define RTCDST_STAMP_BM_LAST    8'h1F
`define RTCDST_SPRING_MONTH     8'h20
`define RTCDST_SPRING_WEEK_DAY  8'h21
`define RTCDST_SPRING_DATE      8'h22
`define RTCDST_SPRING_HOUR      8'h23
`define RTCDST_FALL_MONTH       8'h24
`define RTCDST_FALL_WEEK_DAY    8'h25
`define RTCDST_FALL_DATE        8'h26
`define RTCDST_FALL_HOUR        8'h27
`define RTCDST_TEMP_LOW_ADDR    8'h28
`define RTCDST_TEMP_HIGH_ADDR   8'h29

// field positions
`define RTCDST_ALARM_EN_BIT     7
`define RTCDST_ALARM_FLAG_BIT   4
`define RTCDST_ADJ_FLAG_BIT     5
`define RTCDST_PULSE_MODE_BIT   6
`define RTCDST_CLEAR_BIT        6
`define RTCDST_TSE_BIT          7
`define RTCDST_SAVING_TIME_ENABLE_BIT         7
`define RTCDST_PRIO_BIT         6
`define RTCDST_LAST_WEEK        3'h7

// field masks and reset values
`define RTCDST_MONTH_MASK       8'h1F
`define RTCDST_WEEK_DAY_MASK    8'h7F
`define RTCDST_DATE_MASK        8'h3F
`define RTCDST_HOUR_MASK        8'h3F
`define RTCDST_SPRING_MONTH_RST 8'h00
`define RTCDST_FALL_MONTH_RST   8'h10
`define RTCDST_FIELD_RST        8'h00

// counts
`define RTCDST_ALARM_N          6
`define RTCDST_STAMP_N          5

`endif

// File: rtl/rtcdst_pkg.sv
`default_nettype none
package rtcdst_pkg;
   typedef logic [7:0] rtcdst_byte_t;
   typedef enum logic {
      RTCDST_ALM_SINGLE = 1'b0,
      RTCDST_ALM_PULSE  = 1'b1
   } rtcdst_alm_mode_t;
endpackage
`default_nettype wire

// File: tb/rtcdst_assertions.sv
`default_nettype none
module rtcdst_assertions (
   input wire logic                     i_clk,
   input wire logic                     i_rst_n,
   input wire logic                     i_reg_wr,
   input wire logic                     i_reg_rd,
   input wire rtcdst_pkg::rtcdst_byte_t i_reg_addr,
   input wire rtcdst_pkg::rtcdst_byte_t i_reg_wdata,
   input wire rtcdst_pkg::rtcdst_byte_t o_reg_rdata,
   input wire logic                     i_time_tick,
   input wire rtcdst_pkg::rtcdst_byte_t i_sec,
   input wire rtcdst_pkg::rtcdst_byte_t i_min,
   input wire logic                     o_temp_conv_en,
   input wire logic                     o_dst_advance,
   input wire logic                     o_dst_retard,
   input wire logic                     o_alarm_irq_n
);
   import rtcdst_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_rd(logic [7:0] a);
      i_reg_rd && i_reg_addr == a;
   endsequence
   sequence s_hour_tick;
      i_time_tick && i_sec == 8'h00 && i_min == 8'h00;
   endsequence
   property p_conv_follow;
      logic v;
      (i_reg_wr && i_reg_addr == 8'h0D, v = i_reg_wdata[7])
         |=> o_temp_conv_en == v;
   endproperty
   chk_adv_cause: assert property (o_dst_advance |-> $past(i_time_tick)
      && $past(i_sec) == 8'h00 && $past(i_min) == 8'h00)
      else $error("advance without hour tick");
   chk_ret_cause: assert property (o_dst_retard |-> $past(i_time_tick)
      && $past(i_sec) == 8'h00 && $past(i_min) == 8'h00)
      else $error("retard without hour tick");
   chk_adj_single: assert property (s_hour_tick ##1
      (o_dst_advance || o_dst_retard) |=> !(o_dst_advance || o_dst_retard))
      else $error("hour adjust pulse too long");
   chk_never_both: assert property (!(o_dst_advance && o_dst_retard))
      else $error("advance and retard together");
   chk_irq_cause: assert property ($fell(o_alarm_irq_n) |-> $past(i_time_tick))
      else $error("alarm without time tick");
   chk_conv_follow: assert property (p_conv_follow)
      else $error("sense enable not taken from write");
   chk_conv_stable: assert property (!(i_reg_wr && i_reg_addr == 8'h0D)
      |=> $stable(o_temp_conv_en))
      else $error("sense enable changed without write");
   chk_supply_zero: assert property (s_rd(8'h09) |=> o_reg_rdata == 8'h00)
      else $error("clear control did not read zero");
   chk_temp_high: assert property (s_rd(8'h29) |=> o_reg_rdata[7:2] == 6'h00)
      else $error("temperature high bits not zero");
   chk_spring_mask: assert property (s_rd(8'h20) |=> o_reg_rdata[6:5] == 2'h0)
      else $error("spring month reserved bits set");
   chk_fall_mask: assert property (s_rd(8'h24) |=> o_reg_rdata[7:5] == 3'h0)
      else $error("fall month reserved bits set");
endmodule
bind rtcdst_top rtcdst_assertions chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
   .i_time_tick(i_time_tick), .i_sec(i_sec), .i_min(i_min),
   .o_temp_conv_en(o_temp_conv_en), .o_dst_advance(o_dst_advance),
   .o_dst_retard(o_dst_retard), .o_alarm_irq_n(o_alarm_irq_n));
`default_nettype wire

// File: tb/rtcdst_host.sv
`default_nettype none
module rtcdst_host (
   input  wire logic                     i_clk,
   output logic                          o_wr,
   output logic                          o_rd,
   output rtcdst_pkg::rtcdst_byte_t      o_addr,
   output rtcdst_pkg::rtcdst_byte_t      o_wdata,
   input  wire rtcdst_pkg::rtcdst_byte_t i_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   import rtcdst_pkg::*;
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end
   task automatic wr(input rtcdst_byte_t a, input rtcdst_byte_t d);
      @(posedge i_clk);
      #1;
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(posedge i_clk);
      #1;
      o_wr = 1'b0;
      // released lines must not keep looking valid
      o_addr = ~a;
      o_wdata = ~d;
   endtask
   task automatic rd(input rtcdst_byte_t a, output rtcdst_byte_t d);
      @(posedge i_clk);
      #1;
      o_addr = a;
      o_rd = 1'b1;
      @(posedge i_clk);
      #1;
      o_rd = 1'b0;
      o_addr = ~a;
      d = i_rdata;
   endtask
endmodule
`default_nettype wire

// File: tb/rtc_dst_timestamp_temp_test.sv
`default_nettype none
module rtc_dst_timestamp_temp_test;
   timeunit 1ns;
   timeprecision 100ps;
   import rtcdst_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, reg_wr, reg_rd, tick_p = 1'b0;
   logic on_bat = 1'b0, tvalid = 1'b0, conv_en, adv, ret, irq_n;
   rtcdst_byte_t addr, wdata, rdata, sec = 8'h00, min = 8'h00;
   rtcdst_byte_t hour = 8'h00, date = 8'h01, month = 8'h01, dow = 8'h00;
   logic [9:0] tsample = 10'h000;
   int num_errors = 0, total_checks = 0;
   always #2.5 clk = ~clk;
   rtcdst_host host_u (.i_clk(clk), .o_wr(reg_wr), .o_rd(reg_rd),
      .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata));
   rtcdst_top #(.TEMP_W(10)) dut_u (.i_clk(clk), .i_rst_n(rst_n),
      .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_time_tick(tick_p),
      .i_sec(sec), .i_min(min), .i_hour(hour), .i_date(date),
      .i_month(month), .i_dow(dow), .i_leap_year(1'b0),
      .i_on_battery(on_bat), .i_temp_valid(tvalid),
      .i_temp_sample(tsample), .o_temp_conv_en(conv_en),
      .o_dst_advance(adv), .o_dst_retard(ret), .o_alarm_irq_n(irq_n));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [9:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   function automatic rtcdst_byte_t bcd(input int n);
      return rtcdst_byte_t'(((n / 10) << 4) | (n % 10));
   endfunction
   function automatic rtcdst_byte_t dst_mask(input int i);
      case (i)
         0: return 8'h9F;
         1, 5: return 8'h7F;
         4: return 8'h1F;
         default: return 8'h3F;
      endcase
   endfunction
   function automatic logic [9:0] exp_temp(input logic [9:0] a, b);
      logic [10:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[10:1];
   endfunction
   task automatic tick(input rtcdst_byte_t s, m);
      @(posedge clk);
      #1;
      sec = s;
      min = m;
      tick_p = 1'b1;
      @(posedge clk);
      #1;
      tick_p = 1'b0;
   endtask
   task automatic sample(input logic [9:0] v);
      @(posedge clk);
      #1;
      tsample = v;
      tvalid = 1'b1;
      @(posedge clk);
      #1;
      tvalid = 1'b0;
      tsample = ~v;
   endtask
   // random time, then a supply change; returns the time captured
   task automatic power(input logic b, output rtcdst_byte_t t [5]);
      t = '{bcd($urandom_range(0, 59)), bcd($urandom_range(0, 59)),
            bcd($urandom_range(1, 12)), bcd($urandom_range(1, 28)),
            bcd($urandom_range(1, 12))};
      sec = t[0];
      min = t[1];
      hour = t[2];
      date = t[3];
      month = t[4];
      on_bat = b;
      repeat (3) @(posedge clk);
   endtask
   task automatic check_stamp(input rtcdst_byte_t b, input rtcdst_byte_t t [5]);
      rtcdst_byte_t v;
      for (int i = 0; i < 5; i++) begin
         host_u.rd(b + 8'(i), v);
         check("stamp byte", v, t[i]);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (50000) @(posedge clk);
      num_errors++;
      print_verdict();
   end
   initial begin
      rtcdst_byte_t v, rv, a [5], b [5];
      rtcdst_byte_t z [5] = '{default: 8'h00};
      logic [9:0] s1, s2, code;
      void'($urandom(32'hB87D));
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      for (int i = 0; i < 8; i++) begin
         host_u.rd(8'h20 + 8'(i), v);
         check("dst reset", v, (i == 4) ? 8'h10 : 8'h00);
      end
      check_stamp(8'h16, z);
      check_stamp(8'h1B, z);
      for (int i = 0; i < 8; i++) begin
         v = rtcdst_byte_t'($urandom);
         host_u.wr(8'h20 + 8'(i), v);
         host_u.rd(8'h20 + 8'(i), rv);
         check("dst field", rv, v & dst_mask(i));
      end
      host_u.wr(8'h20, 8'h00);
      host_u.wr(8'h28, 8'hA5);
      host_u.rd(8'h28, v);
      check("temp read only", v, 8'h00);
      host_u.rd(8'h2A, v);
      check("unmapped", v, 8'h00);
      // pulse alarm on seconds 30, flag never cleared
      host_u.wr(8'h08, 8'h40);
      host_u.wr(8'h10, 8'hB0);
      for (int k = 0; k < 4; k++) begin
         tick((k % 2) ? 8'h30 : 8'h29, bcd(k / 2 + 1));
         check("alarm irq", irq_n, (k % 2) ? 1'b0 : 1'b1);
         @(posedge clk);
         #1;
         check("alarm irq end", irq_n, 1'b1);
      end
      host_u.rd(8'h07, v);
      check("alarm flag", v[4], 1'b1);
      host_u.wr(8'h10, 8'h30);
      tick(8'h30, 8'h04);
      check("alarm disabled", irq_n, 1'b1);
      host_u.wr(8'h11, 8'h85);
      tick(8'h17, 8'h05);
      check("minute alarm", irq_n, 1'b0);
      host_u.wr(8'h11, 8'h00);
      // supply change stamps
      power(1'b1, a);
      check_stamp(8'h16, a);
      power(1'b0, b);
      check_stamp(8'h1B, b);
      power(1'b1, b);
      check_stamp(8'h16, a);
      power(1'b0, b);
      check_stamp(8'h1B, b);
      host_u.wr(8'h09, 8'h40);
      check_stamp(8'h16, z);
      check_stamp(8'h1B, z);
      power(1'b1, a);
      check_stamp(8'h16, a);
      on_bat = 1'b0;
      // spring by week 2, sunday, march, 02h in 24h format
      hour = 8'h41;
      dow = 8'h00;
      month = 8'h03;
      host_u.wr(8'h21, 8'h50);
      host_u.wr(8'h22, 8'h15);
      host_u.wr(8'h23, 8'h02);
      host_u.wr(8'h20, 8'h83);
      hour = 8'h42;
      date = 8'h15;
      tick(8'h00, 8'h00);
      check("spring wrong week", adv, 1'b0);
      date = 8'h08;
      tick(8'h00, 8'h00);
      check("spring advance", adv, 1'b1);
      host_u.rd(8'h07, v);
      check("adjusted set", v[5], 1'b1);
      host_u.wr(8'h20, 8'h03);
      host_u.rd(8'h07, v);
      check("adjusted cleared", v[5], 1'b0);
      host_u.wr(8'h21, 8'h7B);
      host_u.wr(8'h20, 8'h83);
      dow = 8'h03;
      date = 8'h18;
      tick(8'h00, 8'h00);
      check("not last week", adv, 1'b0);
      date = 8'h25;
      tick(8'h00, 8'h00);
      check("last week", adv, 1'b1);
      host_u.wr(8'h24, 8'h10);
      host_u.wr(8'h25, 8'h00);
      host_u.wr(8'h26, 8'h25);
      host_u.wr(8'h27, 8'h02);
      month = 8'h10;
      hour = 8'h02;
      dow = 8'h06;
      tick(8'h00, 8'h00);
      check("fall retard", ret, 1'b1);
      host_u.rd(8'h07, v);
      check("adjusted fall", v[5], 1'b0);
      // temperature pairs
      host_u.wr(8'h0D, 8'h80);
      check("sense on", conv_en, 1'b1);
      for (int k = 0; k < 3; k++) begin
         s1 = 10'($urandom_range(446, 726));
         s2 = 10'($urandom_range(446, 726));
         sample(s1);
         sample(s2);
         host_u.rd(8'h28, v);
         host_u.rd(8'h29, rv);
         check("temp code", {rv[1:0], v}, exp_temp(s1, s2));
      end
      code = exp_temp(s1, s2);
      host_u.wr(8'h0D, 8'h00);
      sample(10'h3FF);
      sample(10'h001);
      host_u.rd(8'h28, v);
      host_u.rd(8'h29, rv);
      check("temp held", {rv[1:0], v}, code);
      print_verdict();
   end
endmodule
`default_nettype wire
